// ==== core/wpe_edge_select.sv ====
// Wakeup pin edge select registers, edge detectors and wakeup flags for pins 4 to 15.
//
// Contract
// - Each 2-bit field decodes 00 as disabled, 01 rising, 10 falling and 11 any change.
// - Register index 1h holds pins 7..4, pin 7 in bits 7-6 down to pin 4 in bits 1-0.
// - Register index 2h holds pins 11..8, pin 11 in bits 7-6 down to pin 8 in bits 1-0.
// - Register index 3h holds pins 15..12, pin 15 in bits 7-6 down to pin 12 in bits 1-0.
// - The chip reset that excludes very-low-leakage exits clears every bit to zero.
// - Other resets, including very-low-leakage wakeup, leave the registers unchanged.
// - Only supervisor writes are accepted; a user write is blocked and gets a bus error.
// - Outside low-leakage modes the detectors are static while registers stay accessible.
// - A set wakeup flag stays set even if its pin field is written back to disabled.
`timescale 1ns/1ps
`default_nettype none
module wpe_edge_select
   import wpe_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [WPE_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [2:0] pprot,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic low_leakage_mode,
   input wire logic [WPE_NUM_PINS-1:0] external_wakeup_input,
   output logic [WPE_NUM_PINS-1:0] pin_detect_enable,
   output logic [WPE_NUM_PINS-1:0] pin_detect_pulse,
   output logic [WPE_NUM_PINS-1:0] pin_wakeup_flag
);

   // Decodes one select field against the previous and current pin level.
   function automatic logic edge_match(input logic [1:0] sel, input logic prev,
                                       input logic cur);
      logic rise;
      logic fall;
      rise = ~prev & cur;
      fall = prev & ~cur;
      case (wpe_sel_t'(sel))
         WPE_SEL_RISE: edge_match = rise;
         WPE_SEL_FALL: edge_match = fall;
         WPE_SEL_ANY: edge_match = rise | fall;
         default: edge_match = 1'b0;
      endcase
   endfunction

   logic [7:0] wake_pins_4_to_7_edge_select_ff;
   logic [7:0] wake_pins_8_to_11_edge_select_ff;
   logic [7:0] wake_pins_12_to_15_edge_select_ff;
   logic [WPE_NUM_PINS-1:0] pin_prev_ff;
   logic [WPE_NUM_PINS-1:0] pin_flag_ff;
   logic [WPE_NUM_PINS-1:0] nxt_pin_flag;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic pslverr_ff;
   logic [23:0] all_sel;
   logic [WPE_NUM_PINS-1:0] detect;
   logic [WPE_NUM_PINS-1:0] flag_clear;

   // Address decode; the index is the byte address divided by four.
   wire [WPE_ADDR_W-1:0] byte_base = {paddr[WPE_ADDR_W-1:2], 2'b00};
   wire [7:0] reg_index = paddr[9:2];
   wire aligned = (paddr[1:0] == 2'b00) && (byte_base[WPE_ADDR_W-1:10] == 2'b00);
   wire hit_pe_lo = aligned && (reg_index == WPE_IDX_PINS_4_TO_7);
   wire hit_pe_mid = aligned && (reg_index == WPE_IDX_PINS_8_TO_11);
   wire hit_pe_hi = aligned && (reg_index == WPE_IDX_PINS_12_TO_15);
   wire hit_flag_lo = aligned && (reg_index == WPE_IDX_FLAGS_LO);
   wire hit_flag_hi = aligned && (reg_index == WPE_IDX_FLAGS_HI);
   wire mapped = hit_pe_lo | hit_pe_mid | hit_pe_hi | hit_flag_lo | hit_flag_hi;
   wire access_end = psel & penable;
   // A user-mode write is refused outright so nothing changes.
   wire user_write = pwrite & ~pprot[0];
   wire bad_access = ~mapped | user_write;
   wire wr_ok = access_end & pwrite & ~bad_access;
   wire rd_setup = psel & ~penable & ~pwrite;

   // Every transfer completes in its first access cycle.
   assign pready = psel & penable;
   assign pslverr = pslverr_ff;
   assign prdata = prdata_ff;

   // Flat view of all twelve fields; pin 4 sits at the bottom.
   assign all_sel = {wake_pins_12_to_15_edge_select_ff, wake_pins_8_to_11_edge_select_ff,
                     wake_pins_4_to_7_edge_select_ff};

   // Per-pin detection; the detectors stay quiet outside low-leakage modes.
   always_comb begin
      for (int i = 0; i < WPE_NUM_PINS; i++) begin
         pin_detect_enable[i] = (all_sel[2*i +: 2] != WPE_SEL_OFF);
         detect[i] = low_leakage_mode &
            edge_match(all_sel[2*i +: 2], pin_prev_ff[i], external_wakeup_input[i]);
      end
   end
   assign pin_detect_pulse = detect;
   assign pin_wakeup_flag = pin_flag_ff;

   // Write-one-to-clear of flags; a detection in the same cycle wins.
   assign flag_clear = wr_ok & hit_flag_lo ? {4'h0, pwdata[7:0]} :
                       wr_ok & hit_flag_hi ? {pwdata[3:0], 8'h00} : 12'h000;
   assign nxt_pin_flag = (pin_flag_ff & ~flag_clear) | detect;

   // Read mux, captured in the setup cycle so data comes from a flip-flop.
   always_comb begin
      nxt_prdata = 32'h0000_0000;
      if (hit_pe_lo) begin
         nxt_prdata[7:0] = wake_pins_4_to_7_edge_select_ff;
      end else if (hit_pe_mid) begin
         nxt_prdata[7:0] = wake_pins_8_to_11_edge_select_ff;
      end else if (hit_pe_hi) begin
         nxt_prdata[7:0] = wake_pins_12_to_15_edge_select_ff;
      end else if (hit_flag_lo) begin
         nxt_prdata[7:0] = pin_flag_ff[7:0];
      end else if (hit_flag_hi) begin
         nxt_prdata[3:0] = pin_flag_ff[11:8];
      end
   end

   // Configuration registers; only the chip reset that skips very-low-leakage exits
   // reaches this reset input, so other resets leave the contents alone.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wake_pins_4_to_7_edge_select_ff <= WPE_EDGE_SELECT_RESET;
         wake_pins_8_to_11_edge_select_ff <= WPE_EDGE_SELECT_RESET;
         wake_pins_12_to_15_edge_select_ff <= WPE_EDGE_SELECT_RESET;
      end else if (wr_ok) begin
         if (hit_pe_lo) wake_pins_4_to_7_edge_select_ff <= pwdata[7:0];
         if (hit_pe_mid) wake_pins_8_to_11_edge_select_ff <= pwdata[7:0];
         if (hit_pe_hi) wake_pins_12_to_15_edge_select_ff <= pwdata[7:0];
      end
   end

   // Pin history and flags; the history follows the pins in every mode.
   // The history resets low, so a pin held high through reset looks like a rise; the same
   // reset clears every select field, so that pin raises no flag whatever low_leakage_mode is.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pin_prev_ff <= 12'h000;
         pin_flag_ff <= 12'h000;
      end else begin
         pin_prev_ff <= external_wakeup_input;
         pin_flag_ff <= nxt_pin_flag;
      end
   end

   // Bus answer registers.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prdata_ff <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else begin
         if (rd_setup) prdata_ff <= nxt_prdata;
         pslverr_ff <= psel & ~penable & bad_access;
      end
   end

   // Checks kept next to the logic.
   sequence s_user_write;
      psel && penable && pwrite && !pprot[0];
   endsequence

   // Setup and then access of a read from the pins 4 to 7 register.
   sequence s_lo_read;
      psel && !penable && !pwrite && hit_pe_lo ##1 psel && penable;
   endsequence

   // Accepted write that puts pin 4 back to the disabled code.
   sequence s_pin4_off_write;
      wr_ok && hit_pe_lo && (pwdata[1:0] == 2'b00);
   endsequence

   a_user_write_err: assert property (@(posedge clk) disable iff (reset)
      s_user_write |-> pslverr) else $error("user write not flagged");
   a_user_write_blocked: assert property (@(posedge clk) disable iff (reset)
      s_user_write |=> $stable(all_sel)) else $error("user write changed config");
   a_lo_write_lands: assert property (@(posedge clk) disable iff (reset)
      wr_ok && hit_pe_lo |=> wake_pins_4_to_7_edge_select_ff == $past(pwdata[7:0]))
      else $error("low config write lost");
   a_pe_write_lands: assert property (@(posedge clk) disable iff (reset)
      wr_ok && hit_pe_mid |=> wake_pins_8_to_11_edge_select_ff == $past(pwdata[7:0]))
      else $error("config write lost");
   a_hi_write_lands: assert property (@(posedge clk) disable iff (reset)
      wr_ok && hit_pe_hi |=> wake_pins_12_to_15_edge_select_ff == $past(pwdata[7:0]))
      else $error("high config write lost");
   a_lo_read_data: assert property (@(posedge clk) disable iff (reset)
      s_lo_read |-> prdata == {24'h000000, $past(wake_pins_4_to_7_edge_select_ff)})
      else $error("config read wrong");
   a_rise_detect: assert property (@(posedge clk) disable iff (reset)
      low_leakage_mode && all_sel[1:0] == 2'b01 && !pin_prev_ff[0] && external_wakeup_input[0]
      |-> pin_detect_pulse[0]) else $error("rising edge missed");
   a_fall_detect: assert property (@(posedge clk) disable iff (reset)
      low_leakage_mode && all_sel[1:0] == 2'b10 && pin_prev_ff[0] && !external_wakeup_input[0]
      |-> pin_detect_pulse[0]) else $error("falling edge missed");
   a_any_detect: assert property (@(posedge clk) disable iff (reset)
      low_leakage_mode && all_sel[23:22] == 2'b11
      && pin_prev_ff[11] != external_wakeup_input[11] |-> pin_detect_pulse[11])
      else $error("pin change missed");
   a_fall_no_rise: assert property (@(posedge clk) disable iff (reset)
      all_sel[1:0] == 2'b10 && !pin_prev_ff[0] |-> !pin_detect_pulse[0])
      else $error("falling select fired on rise");
   a_pulse_needs_change: assert property (@(posedge clk) disable iff (reset)
      pin_detect_pulse[5] |-> pin_prev_ff[5] != external_wakeup_input[5])
      else $error("pulse without pin change");
   a_static_idle: assert property (@(posedge clk) disable iff (reset)
      !low_leakage_mode |-> pin_detect_pulse == 12'h000) else $error("detector active");
   a_flag_set: assert property (@(posedge clk) disable iff (reset)
      pin_detect_pulse[0] |=> pin_wakeup_flag[0]) else $error("flag not set");
   a_flag_sticky: assert property (@(posedge clk) disable iff (reset)
      pin_flag_ff[0] && !flag_clear[0] |=> pin_flag_ff[0]) else $error("flag dropped");
   a_flag_kept_off: assert property (@(posedge clk) disable iff (reset)
      s_pin4_off_write ##0 pin_flag_ff[0] |=> pin_flag_ff[0])
      else $error("flag lost when pin disabled");
   a_off_disables: assert property (@(posedge clk) disable iff (reset)
      all_sel[23:22] == 2'b00 |-> !pin_detect_enable[11] && !pin_detect_pulse[11])
      else $error("disabled pin active");
   // The fields move only on an accepted write, which is what lets resets other than
   // the chip reset on this input leave the configuration alone.
   a_cfg_write_only: assert property (@(posedge clk) disable iff (reset)
      !wr_ok |=> $stable(all_sel)) else $error("config changed without write");
   a_reset_clears: assert property (@(posedge clk)
      $fell(reset) |-> all_sel == 24'h000000) else $error("config not cleared");

endmodule
`default_nettype wire

// ==== core/wpe_pkg.sv ====
// Package of constants for the wakeup pin edge select register bank.
package wpe_pkg;
   // Printed offsets are not multiples of four, so they are register indices.
   localparam logic [7:0] WPE_IDX_PINS_4_TO_7 = 8'h01;
   localparam logic [7:0] WPE_IDX_PINS_8_TO_11 = 8'h02;
   localparam logic [7:0] WPE_IDX_PINS_12_TO_15 = 8'h03;
   localparam logic [7:0] WPE_IDX_FLAGS_LO = 8'h04;
   localparam logic [7:0] WPE_IDX_FLAGS_HI = 8'h05;
   localparam int WPE_ADDR_W = 12;
   localparam logic [7:0] WPE_EDGE_SELECT_RESET = 8'h00;
   localparam logic [7:0] WPE_FLAG_RESET = 8'h00;
   localparam int WPE_FIRST_PIN = 4;
   localparam int WPE_NUM_PINS = 12;
   localparam int WPE_FIELD_W = 2;
   // Detection select codes.
   typedef enum logic [1:0] {
      WPE_SEL_OFF = 2'b00,
      WPE_SEL_RISE = 2'b01,
      WPE_SEL_FALL = 2'b10,
      WPE_SEL_ANY = 2'b11
   } wpe_sel_t;
endpackage

// ==== test/tb_wakeup_pin_edge_config.sv ====
// Self-checking testbench for the wakeup pin edge select register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_wakeup_pin_edge_config;
   import wpe_pkg::*;
   logic clk, reset, psel, penable, pwrite, pready, pslverr, mode, mode_want, err;
   logic [11:0] paddr, pins, pin_want, en, pulse, flag, eflag, ep, nw, old;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [2:0] pprot;
   logic [23:0] cfg;
   int fail_count, cmp_count, cyc;
   wpe_edge_select wpe_edge_select_i (.clk(clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .low_leakage_mode(mode),
      .external_wakeup_input(pins), .pin_detect_enable(en), .pin_detect_pulse(pulse),
      .pin_wakeup_flag(flag));
   wpe_pin_model wpe_pin_model_i (.clk(clk), .pin_want(pin_want), .mode_want(mode_want),
      .pins(pins), .mode(mode));
   // Xorshift source, so every run repeats the same stimulus.
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Expected detect of one pin from its select code and two samples.
   function automatic logic edet(input logic [1:0] s, input logic p, input logic c);
      return (s == WPE_SEL_RISE && !p && c) || (s == WPE_SEL_FALL && p && !c)
         || (s == WPE_SEL_ANY && p != c);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; the request is held until pready is seen high at an edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [2:0] p);
      // Starting on a fresh edge keeps back-to-back calls from driving psel twice in one step.
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pprot <= p;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic setcfg(input logic [23:0] c);
      cfg = c;
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, 12'(4 * i + 4), {24'h0, c[8 * i +: 8]}, 3'h1);
         chk(err, 32'h0);
      end
   endtask
   task automatic rdcfg();
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, 12'(4 * i + 4), 32'h0, 3'h1);
         chk(rd, {24'h0, cfg[8 * i +: 8]});
      end
      for (int k = 0; k < 12; k++) chk(en[k], cfg[2 * k +: 2] != 2'b00);
   endtask
   // Random pin steps; the flag is checked one edge after each detect.
   task automatic run();
      for (int t = 0; t < 40; t++) begin
         if (t % 8 == 0) setcfg(24'(xs()));
         if (t % 8 == 0) rdcfg();
         // New levels are handed over on an edge and reach the pins on the next one.
         @(posedge clk);
         nw = 12'(xs());
         pin_want <= nw;
         @(posedge clk);
         #1;
         for (int k = 0; k < 12; k++) ep[k] = mode_want & edet(cfg[2 * k +: 2], old[k], nw[k]);
         chk(pulse, ep);
         eflag = eflag | ep;
         old = nw;
         @(posedge clk);
         #1;
         chk(flag, eflag);
      end
   endtask
   task automatic results();
      if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // The full run needs well under a thousand cycles; this ceiling cuts a hang.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         $display("Error %0t: timeout", $time);
         fail_count++;
         results();
      end
   end
   initial begin
      {reset, psel, penable, pwrite, mode_want} = 5'h10;
      {paddr, pwdata, pprot, pin_want, cfg, eflag, old} = '0;
      seed = 32'h0000_8A0C;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rdcfg();
      apb(1'b1, 12'h004, 32'h000000FF, 3'h0);
      chk(err, 32'h1);
      apb(1'b0, 12'h040, 32'h0, 3'h1);
      chk({err, rd[30:0]}, 32'h80000000);
      rdcfg();
      setcfg(24'hFFFFFF);
      rdcfg();
      mode_want <= 1'b1;
      run();
      @(posedge clk);
      mode_want <= 1'b0;
      run();
      setcfg(24'h000000);
      rdcfg();
      chk(flag, eflag);
      // Flags read back through their registers and clear when ones are written.
      apb(1'b0, 12'h010, 32'h0, 3'h1);
      chk(rd, {24'h0, eflag[7:0]});
      apb(1'b0, 12'h014, 32'h0, 3'h1);
      chk(rd, {28'h0, eflag[11:8]});
      eflag = 12'h000;
      apb(1'b1, 12'h010, 32'h0000_00FF, 3'h1);
      apb(1'b1, 12'h014, 32'h0000_000F, 3'h1);
      apb(1'b0, 12'h010, 32'h0, 3'h1);
      chk(rd, 32'h0);
      chk(flag, eflag);
      setcfg(24'(xs()));
      reset <= 1'b1;
      @(posedge clk);
      reset <= 1'b0;
      cfg = 24'h0;
      rdcfg();
      chk(flag, 32'h0);
      results();
   end
endmodule
`default_nettype wire

// ==== test/wpe_pin_model.sv ====
// Partner model of the external wakeup pins and the power mode controller.
`timescale 1ns/1ps
`default_nettype none
module wpe_pin_model (
   input wire logic clk,
   input wire logic [11:0] pin_want,
   input wire logic mode_want,
   output logic [11:0] pins,
   output logic mode
);
   // Levels change only just after an edge, so the unit never sees a mid-cycle glitch.
   always_ff @(posedge clk) begin
      pins <= pin_want;
      mode <= mode_want;
   end
endmodule
`default_nettype wire
